// File: include/dss_pkg.sv
// Constants and types shared by the setup switch decoder files
`default_nettype none
package dss_pkg;
   // Register byte offsets
   localparam logic [5:0] OFS_CTRL = 6'h00;
   localparam logic [5:0] OFS_OPSEL = 6'h04;
   localparam logic [5:0] OFS_COMMSEL = 6'h08;
   localparam logic [5:0] OFS_LINECNT = 6'h0c;
   localparam logic [5:0] OFS_FB_SOURCE = 6'h10;
   localparam logic [5:0] OFS_AUXDIV = 6'h14;
   localparam logic [5:0] OFS_STATUS = 6'h18;
   localparam logic [5:0] OFS_LINES = 6'h1c;
   localparam logic [5:0] OFS_AUXPOS = 6'h20;
   // Field positions
   localparam int CTRL_FACTORY_BIT = 0;
   localparam int ST_OPERATION_SELECT_PARAM_BIT = 0;
   localparam int ST_FBTYPE_BIT = 1;
   localparam int ST_ENC_EN_BIT = 2;
   localparam int ST_AUX_RUN_BIT = 3;
   localparam int ST_AUX_SEC_BIT = 4;
   localparam int ST_DIP_LSB = 8;
   localparam int ST_ROT_LSB = 12;
   // Selection parameter values, aux feedback types and divider states
   typedef enum logic [1:0] {
      DSS_SEL_FOLLOW_DIP = 2'b00,
      DSS_SEL_FORCE_LOW = 2'b01,
      DSS_SEL_FORCE_HIGH = 2'b10
   } dss_sel_t;
   typedef enum logic [2:0] {
      DSS_AUX_INC = 3'b000,
      DSS_AUX_INC_HALLS = 3'b001,
      DSS_AUX_SINCOS = 3'b010,
      DSS_AUX_SINCOS_HALLS = 3'b011,
      DSS_AUX_ABSOLUTE = 3'b100
   } dss_aux_t;
   typedef enum logic {
      DSS_DIV_LOAD = 1'b0,
      DSS_DIV_RUN = 1'b1
   } dss_div_state_t;
   // Reset values
   localparam logic [1:0] RST_OPSEL = 2'b00;
   localparam logic [1:0] RST_COMMSEL = 2'b00;
   localparam logic [15:0] RST_LINECNT = 16'h01f4;
   localparam logic RST_FB_SOURCE = 1'b0;
   localparam logic [15:0] RST_AUXDIV = 16'h0001;
   // Timing
   localparam int CLK_HZ = 20000000;
   localparam int DEBOUNCE_TIME_US = 10000;
   localparam int DEBOUNCE_CYCLES = DEBOUNCE_TIME_US * (CLK_HZ / 1000000);
   localparam int DIV_STEPS = 32;
endpackage : dss_pkg
`default_nettype wire

// File: core/dss_switch_filter.sv
// Two-stage synchroniser and stability filter for the setup switches
`timescale 1ns/100ps
`default_nettype none
module dss_switch_filter #(
   parameter int WIDTH = 8,
   parameter int STABLE_CYCLES = 200000
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] raw,
   output logic [WIDTH-1:0] filtered
);
   logic [WIDTH-1:0] sync1_reg;
   logic [WIDTH-1:0] sync2_reg;
   logic [WIDTH-1:0] cand_reg;
   logic [WIDTH-1:0] out_reg;
   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;
   wire changed = sync2_reg != cand_reg;
   wire settled = cnt_reg >= 32'(STABLE_CYCLES - 1);

   // A new value restarts the wait so a bouncing contact never gets through
   assign cnt_next = changed ? 32'h00000000 : (settled ? cnt_reg : cnt_reg + 32'h00000001);

   always_ff @(posedge clk) begin
      if (reset) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         cand_reg <= '0;
         cnt_reg <= '0;
      end else begin
         sync1_reg <= raw;
         sync2_reg <= sync1_reg;
         cand_reg <= sync2_reg;
         cnt_reg <= cnt_next;
      end
   end

   // Out of reset the output holds zero until the switches first settle
   always_ff @(posedge clk) begin
      if (reset) begin
         out_reg <= '0;
      end else if (!changed && settled) begin
         out_reg <= cand_reg;
      end
   end

   assign filtered = out_reg;
endmodule : dss_switch_filter
`default_nettype wire

// File: core/dss_top.sv
// Setup switch decoder with auxiliary sine-cosine position scaling
//
// Contract
// - DIP position one picks torque (down) or velocity (up), position two smart feedback or Hall.
// - A DIP position counts only while its selection parameter follows the switch.
// - A factory default sets both selection parameters back to follow the switches.
// - The rotary switch is read and interpreted according to the active feedback mode.
// - With smart feedback, rotary positions 1 to 9 give 512 to 10000 emulated lines.
// - Rotary position 0 uses the stored line count, limited to its sixteen legal values.
// - The stored line count returns to 500 on factory default and is replaced only by writes of one of its legal values.
// - The emulated encoder output runs only with smart feedback on base or high-res on option card.
// - Aux sine-cosine is interpolated to 65536 steps per cycle, then divided to a count.
// - Plain aux incremental or sine-cosine is secondary only; Hall or absolute may run the motor.
`timescale 1ns/100ps
`default_nettype none
module dss_top #(
   parameter int DEBOUNCE_CYCLES = dss_pkg::DEBOUNCE_CYCLES
) (
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic [5:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic [3:0] DIP_SETUP_SWITCH,
   input wire logic [3:0] ROTARY_SETUP_SWITCH,
   input wire logic SMART_FEEDBACK_PRESENT,
   input wire logic OPTION_HIRES_PRESENT,
   input wire logic [2:0] AUX_FEEDBACK_TYPE,
   input wire logic [15:0] AUX_FINE_ANGLE,
   output logic OPERATION_VELOCITY,
   output logic FEEDBACK_SIX_STEP,
   output logic ENC_OUT_ENABLE,
   output logic [15:0] ENC_LINE_COUNT,
   output logic AUX_COMMUTATE_OK,
   output logic AUX_SECONDARY_OK,
   output logic [31:0] AUX_POSITION
);
   // Emulated line count chosen by rotary position with smart feedback
   function automatic logic [15:0] rotary_lines(input logic [3:0] pos, input logic [15:0] stored);
      unique case (pos)
         4'h1: rotary_lines = 16'd512;
         4'h2: rotary_lines = 16'd1000;
         4'h3: rotary_lines = 16'd1024;
         4'h4: rotary_lines = 16'd2000;
         4'h5: rotary_lines = 16'd2048;
         4'h6: rotary_lines = 16'd4096;
         4'h7: rotary_lines = 16'd5000;
         4'h8: rotary_lines = 16'd8192;
         4'h9: rotary_lines = 16'd10000;
         default: rotary_lines = stored;
      endcase
   endfunction : rotary_lines

   function automatic logic legal_lines(input logic [15:0] v);
      unique case (v)
         16'd128, 16'd512, 16'd1024, 16'd2048, 16'd4096, 16'd8192, 16'd16384, 16'd32768,
         16'd125, 16'd500, 16'd1000, 16'd2000, 16'd2500, 16'd5000, 16'd10000,
         16'd20000: legal_lines = 1'b1;
         default: legal_lines = 1'b0;
      endcase
   endfunction : legal_lines

   // Byte-lane merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction : merge

   // Select between a DIP position and a forced parameter value
   function automatic logic pick(input logic [1:0] sel, input logic dip);
      pick = (sel == dss_pkg::DSS_SEL_FOLLOW_DIP) ? dip : (sel == dss_pkg::DSS_SEL_FORCE_HIGH);
   endfunction : pick

   // Switch filtering
   logic [7:0] switches;
   dss_switch_filter #(
      .WIDTH(8),
      .STABLE_CYCLES(DEBOUNCE_CYCLES)
   ) u_filter (
      .clk(CLK_SYS),
      .reset(RESET),
      .raw({ROTARY_SETUP_SWITCH, DIP_SETUP_SWITCH}),
      .filtered(switches)
   );
   wire [3:0] dip_setup_switch = switches[3:0];
   wire [3:0] rotary_setup_switch = switches[7:4];

   // Registers
   logic [1:0] operation_select_param_reg;
   logic [1:0] commutation_select_param_reg;
   logic [15:0] emulated_line_count_param_reg;
   logic feedback_source_param_reg;
   logic [15:0] aux_position_divider_reg;
   logic wait_reg;
   logic [31:0] rdata_reg;

   // Bus decode: the second cycle of a request is the accepting one
   wire req = AVS_READ | AVS_WRITE;
   wire accept = req & ~wait_reg;
   wire wr = AVS_WRITE & accept;
   wire [31:0] wmerge_lo = merge(32'h00000000, AVS_WRITEDATA, AVS_BYTEENABLE);
   wire wr_ctrl = wr & (AVS_ADDRESS == dss_pkg::OFS_CTRL);
   wire wr_opsel = wr & (AVS_ADDRESS == dss_pkg::OFS_OPSEL) & AVS_BYTEENABLE[0];
   wire wr_commsel = wr & (AVS_ADDRESS == dss_pkg::OFS_COMMSEL) & AVS_BYTEENABLE[0];
   wire wr_linecnt = wr & (AVS_ADDRESS == dss_pkg::OFS_LINECNT);
   wire wr_fb_source = wr & (AVS_ADDRESS == dss_pkg::OFS_FB_SOURCE) & AVS_BYTEENABLE[0];
   wire wr_auxdiv = wr & (AVS_ADDRESS == dss_pkg::OFS_AUXDIV);
   wire factory = wr_ctrl & wmerge_lo[dss_pkg::CTRL_FACTORY_BIT];
   wire [31:0] line_merge = merge({16'h0000, emulated_line_count_param_reg},
                                  AVS_WRITEDATA, AVS_BYTEENABLE);
   wire [31:0] div_merge = merge({16'h0000, aux_position_divider_reg},
                                 AVS_WRITEDATA, AVS_BYTEENABLE);
   wire [15:0] line_wdata = line_merge[15:0];
   wire [15:0] div_wdata = div_merge[15:0];
   // Value 2'b11 is not a selection; writing it leaves the parameter untouched
   wire sel_ok = AVS_WRITEDATA[1:0] != 2'b11;

   always_ff @(posedge CLK_SYS) begin
      if (RESET || factory) begin
         operation_select_param_reg <= dss_pkg::RST_OPSEL;
         commutation_select_param_reg <= dss_pkg::RST_COMMSEL;
      end else begin
         if (wr_opsel && sel_ok) begin
            operation_select_param_reg <= AVS_WRITEDATA[1:0];
         end
         if (wr_commsel && sel_ok) begin
            commutation_select_param_reg <= AVS_WRITEDATA[1:0];
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RESET || factory) begin
         emulated_line_count_param_reg <= dss_pkg::RST_LINECNT;
      end else if (wr_linecnt && legal_lines(line_wdata)) begin
         emulated_line_count_param_reg <= line_wdata;
      end
   end

   // Divider and source are not touched by factory default of the switch parameters
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         feedback_source_param_reg <= dss_pkg::RST_FB_SOURCE;
         aux_position_divider_reg <= dss_pkg::RST_AUXDIV;
      end else begin
         if (wr_fb_source) begin
            feedback_source_param_reg <= AVS_WRITEDATA[0];
         end
         if (wr_auxdiv) begin
            aux_position_divider_reg <= div_wdata;
         end
      end
   end

   // Decoded selections; DIP positions 3 and 4 are deliberately unused
   wire velocity_sel = pick(operation_select_param_reg, dip_setup_switch[0]);
   wire six_step_sel = pick(commutation_select_param_reg, dip_setup_switch[1]);
   wire smart_sel = ~six_step_sel;
   wire [15:0] lines_sel = smart_sel ?
      rotary_lines(rotary_setup_switch, emulated_line_count_param_reg) : 16'h0000;
   wire enc_en_sel = (smart_sel & ~feedback_source_param_reg & SMART_FEEDBACK_PRESENT) |
                     (feedback_source_param_reg & OPTION_HIRES_PRESENT);
   wire aux_run_sel = (AUX_FEEDBACK_TYPE == dss_pkg::DSS_AUX_INC_HALLS) |
                      (AUX_FEEDBACK_TYPE == dss_pkg::DSS_AUX_SINCOS_HALLS) |
                      (AUX_FEEDBACK_TYPE == dss_pkg::DSS_AUX_ABSOLUTE);
   wire aux_sec_sel = AUX_FEEDBACK_TYPE <= dss_pkg::DSS_AUX_ABSOLUTE;

   logic velocity_reg;
   logic six_step_reg;
   logic enc_en_reg;
   logic [15:0] lines_reg;
   logic aux_run_reg;
   logic aux_sec_reg;
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         velocity_reg <= 1'b0;
         six_step_reg <= 1'b0;
         enc_en_reg <= 1'b0;
         lines_reg <= '0;
         aux_run_reg <= 1'b0;
         aux_sec_reg <= 1'b0;
      end else begin
         velocity_reg <= velocity_sel;
         six_step_reg <= six_step_sel;
         enc_en_reg <= enc_en_sel;
         lines_reg <= lines_sel;
         aux_run_reg <= aux_run_sel;
         aux_sec_reg <= aux_sec_sel;
      end
   end

   // Coarse cycle count plus 16-bit fine angle; assumes under a quarter cycle of travel per clock
   logic [15:0] fine_prev_reg;
   logic [15:0] cycles_reg;
   wire fwd_wrap = (fine_prev_reg[15:14] == 2'b11) & (AUX_FINE_ANGLE[15:14] == 2'b00);
   wire back_wrap = (fine_prev_reg[15:14] == 2'b00) & (AUX_FINE_ANGLE[15:14] == 2'b11);
   wire [15:0] cycles_next = fwd_wrap ? cycles_reg + 16'h0001 :
                             (back_wrap ? cycles_reg - 16'h0001 : cycles_reg);
   wire [31:0] raw_position = {cycles_reg, fine_prev_reg};
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         fine_prev_reg <= '0;
         cycles_reg <= '0;
      end else begin
         fine_prev_reg <= AUX_FINE_ANGLE;
         cycles_reg <= cycles_next;
      end
   end

   // Serial restoring divider; a new quotient every 33 clocks keeps the area small
   dss_pkg::dss_div_state_t div_state_reg;
   logic [31:0] quot_reg;
   logic [16:0] rem_reg;
   logic [5:0] step_reg;
   logic [15:0] divisor_reg;
   logic [31:0] pos_reg;
   wire [16:0] rem_shift = {rem_reg[15:0], quot_reg[31]};
   wire rem_ge = rem_shift >= {1'b0, divisor_reg};
   wire [16:0] rem_next = rem_ge ? rem_shift - {1'b0, divisor_reg} : rem_shift;
   wire last_step = step_reg == 6'(dss_pkg::DIV_STEPS - 1);
   // Zero divisor would be meaningless; it divides by one instead
   wire [15:0] divisor_load = (aux_position_divider_reg == 16'h0000) ?
                              16'h0001 : aux_position_divider_reg;
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         div_state_reg <= dss_pkg::DSS_DIV_LOAD;
         quot_reg <= '0;
         rem_reg <= '0;
         step_reg <= '0;
         divisor_reg <= dss_pkg::RST_AUXDIV;
         pos_reg <= '0;
      end else begin
         unique case (div_state_reg)
            dss_pkg::DSS_DIV_LOAD: begin
               quot_reg <= raw_position;
               rem_reg <= '0;
               step_reg <= '0;
               divisor_reg <= divisor_load;
               div_state_reg <= dss_pkg::DSS_DIV_RUN;
            end
            dss_pkg::DSS_DIV_RUN: begin
               quot_reg <= {quot_reg[30:0], rem_ge};
               rem_reg <= rem_next;
               step_reg <= step_reg + 6'h01;
               if (last_step) begin
                  pos_reg <= {quot_reg[30:0], rem_ge};
                  div_state_reg <= dss_pkg::DSS_DIV_LOAD;
               end
            end
         endcase
      end
   end

   // Read data
   wire [31:0] status_word = {16'h0000, rotary_setup_switch, dip_setup_switch, 3'b000,
                              aux_sec_reg, aux_run_reg, enc_en_reg, six_step_reg, velocity_reg};
   logic [31:0] rd_mux;
   always_comb begin
      unique case (AVS_ADDRESS)
         dss_pkg::OFS_OPSEL: rd_mux = {30'h0, operation_select_param_reg};
         dss_pkg::OFS_COMMSEL: rd_mux = {30'h0, commutation_select_param_reg};
         dss_pkg::OFS_LINECNT: rd_mux = {16'h0000, emulated_line_count_param_reg};
         dss_pkg::OFS_FB_SOURCE: rd_mux = {31'h0, feedback_source_param_reg};
         dss_pkg::OFS_AUXDIV: rd_mux = {16'h0000, aux_position_divider_reg};
         dss_pkg::OFS_STATUS: rd_mux = status_word;
         dss_pkg::OFS_LINES: rd_mux = {16'h0000, lines_reg};
         dss_pkg::OFS_AUXPOS: rd_mux = pos_reg;
         default: rd_mux = 32'h00000000;
      endcase
   end

   // One wait state on every access, so read data and waitrequest both come from flops
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         wait_reg <= 1'b1;
         rdata_reg <= '0;
      end else if (req && wait_reg) begin
         wait_reg <= 1'b0;
         rdata_reg <= AVS_READ ? rd_mux : 32'h00000000;
      end else begin
         wait_reg <= 1'b1;
      end
   end

   assign AVS_READDATA = rdata_reg;
   assign AVS_WAITREQUEST = wait_reg;
   assign OPERATION_VELOCITY = velocity_reg;
   assign FEEDBACK_SIX_STEP = six_step_reg;
   assign ENC_OUT_ENABLE = enc_en_reg;
   assign ENC_LINE_COUNT = lines_reg;
   assign AUX_COMMUTATE_OK = aux_run_reg;
   assign AUX_SECONDARY_OK = aux_sec_reg;
   assign AUX_POSITION = pos_reg;
endmodule : dss_top
`default_nettype wire

// File: test/dss_top_asserts.sv
// Port-level assertions for the setup switch decoder
`timescale 1ns/100ps
`default_nettype none
module dss_top_asserts (
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic SMART_FEEDBACK_PRESENT,
   input wire logic OPTION_HIRES_PRESENT,
   input wire logic [2:0] AUX_FEEDBACK_TYPE,
   input wire logic FEEDBACK_SIX_STEP,
   input wire logic ENC_OUT_ENABLE,
   input wire logic [15:0] ENC_LINE_COUNT,
   input wire logic AUX_COMMUTATE_OK,
   input wire logic AUX_SECONDARY_OK
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RESET);
   a_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("bus request not answered after one wait state");
   a_wait_pulse: assert property (!AVS_WAITREQUEST |-> $past(AVS_READ || AVS_WRITE) ##1 AVS_WAITREQUEST)
      else $error("waitrequest low without request or for too long");
   a_rdata_hold: assert property (AVS_WAITREQUEST && $past(AVS_WAITREQUEST) |-> $stable(AVS_READDATA))
      else $error("read data changed outside an access");
   a_enc_enable_cause: assert property (ENC_OUT_ENABLE |-> $past(SMART_FEEDBACK_PRESENT || OPTION_HIRES_PRESENT))
      else $error("encoder output enabled without a feedback device");
   a_six_step_lines: assert property (FEEDBACK_SIX_STEP |-> ENC_LINE_COUNT == 16'h0000)
      else $error("line count present in six-step mode");
   a_line_legal: assert property (ENC_LINE_COUNT inside {16'd0, 16'd125, 16'd128, 16'd500, 16'd512,
      16'd1000, 16'd1024, 16'd2000, 16'd2048, 16'd2500, 16'd4096, 16'd5000, 16'd8192, 16'd10000,
      16'd16384, 16'd20000, 16'd32768}) else $error("illegal emulated line count");
   a_aux_commutate: assert property ($stable(AUX_FEEDBACK_TYPE) && !$past(RESET) |->
      AUX_COMMUTATE_OK == (AUX_FEEDBACK_TYPE inside {3'd1, 3'd3, 3'd4}))
      else $error("commutation permission wrong for aux type");
   a_aux_secondary: assert property ($stable(AUX_FEEDBACK_TYPE) && !$past(RESET) |->
      AUX_SECONDARY_OK == (AUX_FEEDBACK_TYPE <= 3'd4)) else $error("secondary permission wrong");
   a_commutate_sub: assert property (AUX_COMMUTATE_OK |-> AUX_SECONDARY_OK)
      else $error("commutating type not valid as secondary");
endmodule : dss_top_asserts
bind dss_top dss_top_asserts dss_top_asserts_i (.CLK_SYS, .RESET, .AVS_READ, .AVS_WRITE,
   .AVS_READDATA, .AVS_WAITREQUEST, .SMART_FEEDBACK_PRESENT, .OPTION_HIRES_PRESENT,
   .AUX_FEEDBACK_TYPE, .FEEDBACK_SIX_STEP, .ENC_OUT_ENABLE, .ENC_LINE_COUNT, .AUX_COMMUTATE_OK,
   .AUX_SECONDARY_OK);
`default_nettype wire

// File: test/dss_switch_model.sv
// Behavioural setup switches and motor feedback devices
`timescale 1ns/100ps
`default_nettype none
module dss_switch_model (
   output logic [3:0] dip,
   output logic [3:0] rot,
   output logic smart,
   output logic hires,
   output logic [2:0] aux_type,
   output logic [15:0] angle
);
   // Angle starts in the second quarter so no cycle is counted at start-up
   initial begin
      dip = 4'h0;
      rot = 4'h0;
      smart = 1'b0;
      hires = 1'b0;
      aux_type = 3'h0;
      angle = 16'h4000;
   end
   // Callers enter just after a clock edge
   task automatic set_sw(input logic [1:0] pos, input logic [3:0] r);
      dip <= {2'b00, pos};
      rot <= r;
   endtask : set_sw
   task automatic set_fb(input logic s, input logic h, input logic [2:0] t, input logic [15:0] a);
      smart <= s;
      hires <= h;
      aux_type <= t;
      angle <= a;
   endtask : set_fb
endmodule : dss_switch_model
`default_nettype wire

// File: test/tb_drive_setup_switch_decoder.sv
// Self-checking bench for the setup switch decoder
`timescale 1ns/100ps
`default_nettype none
module tb_drive_setup_switch_decoder;
   logic CLK_SYS, RESET, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
   logic [5:0] AVS_ADDRESS;
   logic [31:0] AVS_WRITEDATA, AVS_READDATA, AUX_POSITION, q;
   logic [3:0] AVS_BYTEENABLE, DIP_SETUP_SWITCH, ROTARY_SETUP_SWITCH;
   logic SMART_FEEDBACK_PRESENT, OPTION_HIRES_PRESENT, OPERATION_VELOCITY, FEEDBACK_SIX_STEP;
   logic ENC_OUT_ENABLE, AUX_COMMUTATE_OK, AUX_SECONDARY_OK;
   logic [2:0] AUX_FEEDBACK_TYPE;
   logic [15:0] AUX_FINE_ANGLE, ENC_LINE_COUNT;
   int errors, compares, cycles;
   logic [15:0] lines [10] = '{16'd500, 16'd512, 16'd1000, 16'd1024, 16'd2000, 16'd2048,
      16'd4096, 16'd5000, 16'd8192, 16'd10000};
   always #25 CLK_SYS = ~CLK_SYS;
   dss_top #(.DEBOUNCE_CYCLES(4)) dss_top_i (.CLK_SYS, .RESET, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
      .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .DIP_SETUP_SWITCH,
      .ROTARY_SETUP_SWITCH, .SMART_FEEDBACK_PRESENT, .OPTION_HIRES_PRESENT, .AUX_FEEDBACK_TYPE,
      .AUX_FINE_ANGLE, .OPERATION_VELOCITY, .FEEDBACK_SIX_STEP, .ENC_OUT_ENABLE, .ENC_LINE_COUNT,
      .AUX_COMMUTATE_OK, .AUX_SECONDARY_OK, .AUX_POSITION);
   dss_switch_model dss_switch_model_i (.dip(DIP_SETUP_SWITCH), .rot(ROTARY_SETUP_SWITCH),
      .smart(SMART_FEEDBACK_PRESENT), .hires(OPTION_HIRES_PRESENT), .aux_type(AUX_FEEDBACK_TYPE),
      .angle(AUX_FINE_ANGLE));
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   // Request raised one edge after entry so a release is never reassigned in the same step
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge CLK_SYS);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_WRITE <= wr;
      AVS_READ <= !wr;
      do begin
         @(posedge CLK_SYS);
         n++;
      end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
      chk("waitrequest", 32'h0, {31'h0, AVS_WAITREQUEST});
      q = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
   endtask : bus
   task automatic rd(input string nm, input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask : rd
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge CLK_SYS);
   endtask : wait_cyc
   task stop_test;
      if (errors == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test
   // Whole run needs about 530 cycles
   always @(posedge CLK_SYS) begin
      cycles++;
      if (cycles == 8000) begin
         errors++;
         stop_test();
      end
   end
   initial begin
      CLK_SYS = 1'b0;
      RESET = 1'b1;
      AVS_ADDRESS = 6'h00;
      AVS_READ = 1'b0;
      AVS_WRITE = 1'b0;
      AVS_WRITEDATA = 32'h0;
      AVS_BYTEENABLE = 4'hf;
      errors = 0;
      compares = 0;
      cycles = 0;
      wait_cyc(20);
      RESET <= 1'b0;
      rd("opsel", dss_pkg::OFS_OPSEL, 32'h0);
      rd("commsel", dss_pkg::OFS_COMMSEL, 32'h0);
      rd("linecnt", dss_pkg::OFS_LINECNT, 32'h1f4);
      rd("fb_source", dss_pkg::OFS_FB_SOURCE, 32'h0);
      rd("auxdiv", dss_pkg::OFS_AUXDIV, 32'h1);
      bus(1'b1, 6'h3c, 32'hffffffff);
      rd("unmapped", 6'h3c, 32'h0);
      bus(1'b1, dss_pkg::OFS_LINECNT, 32'd600);
      rd("linecnt", dss_pkg::OFS_LINECNT, 32'h1f4);
      bus(1'b1, dss_pkg::OFS_OPSEL, 32'h3);
      rd("opsel", dss_pkg::OFS_OPSEL, 32'h0);
      dss_switch_model_i.set_fb(1'b1, 1'b0, 3'h0, 16'h4000);
      for (int i = 0; i < 10; i++) begin
         dss_switch_model_i.set_sw(2'b01, i[3:0]);
         wait_cyc(16);
         chk("lines", {16'h0, lines[i]}, {16'h0, ENC_LINE_COUNT});
      end
      chk("velocity", 32'h1, {31'h0, OPERATION_VELOCITY});
      chk("sixstep", 32'h0, {31'h0, FEEDBACK_SIX_STEP});
      chk("enc_en", 32'h1, {31'h0, ENC_OUT_ENABLE});
      dss_switch_model_i.set_sw(2'b01, 4'hc);
      wait_cyc(16);
      chk("lines", 32'd500, {16'h0, ENC_LINE_COUNT});
      bus(1'b1, dss_pkg::OFS_LINECNT, 32'd20000);
      wait_cyc(4);
      chk("lines", 32'd20000, {16'h0, ENC_LINE_COUNT});
      bus(1'b1, dss_pkg::OFS_OPSEL, 32'h1);
      wait_cyc(4);
      chk("velocity", 32'h0, {31'h0, OPERATION_VELOCITY});
      dss_switch_model_i.set_sw(2'b10, 4'h0);
      wait_cyc(16);
      chk("sixstep", 32'h1, {31'h0, FEEDBACK_SIX_STEP});
      chk("lines", 32'h0, {16'h0, ENC_LINE_COUNT});
      chk("enc_en", 32'h0, {31'h0, ENC_OUT_ENABLE});
      bus(1'b1, dss_pkg::OFS_OPSEL, 32'h2);
      bus(1'b1, dss_pkg::OFS_COMMSEL, 32'h1);
      wait_cyc(4);
      chk("velocity", 32'h1, {31'h0, OPERATION_VELOCITY});
      chk("sixstep", 32'h0, {31'h0, FEEDBACK_SIX_STEP});
      chk("lines", 32'd20000, {16'h0, ENC_LINE_COUNT});
      bus(1'b1, dss_pkg::OFS_CTRL, 32'h1);
      wait_cyc(4);
      rd("opsel", dss_pkg::OFS_OPSEL, 32'h0);
      rd("commsel", dss_pkg::OFS_COMMSEL, 32'h0);
      rd("linecnt", dss_pkg::OFS_LINECNT, 32'h1f4);
      chk("velocity", 32'h0, {31'h0, OPERATION_VELOCITY});
      chk("sixstep", 32'h1, {31'h0, FEEDBACK_SIX_STEP});
      dss_switch_model_i.set_sw(2'b00, 4'h0);
      dss_switch_model_i.set_fb(1'b0, 1'b1, 3'h0, 16'h4000);
      wait_cyc(16);
      chk("enc_en", 32'h0, {31'h0, ENC_OUT_ENABLE});
      bus(1'b1, dss_pkg::OFS_FB_SOURCE, 32'h1);
      wait_cyc(4);
      chk("enc_en", 32'h1, {31'h0, ENC_OUT_ENABLE});
      for (int t = 0; t < 8; t++) begin
         dss_switch_model_i.set_fb(1'b0, 1'b0, t[2:0], 16'h4000);
         wait_cyc(4);
         chk("commutate", {31'h0, t == 1 || t == 3 || t == 4}, {31'h0, AUX_COMMUTATE_OK});
         chk("secondary", {31'h0, t < 5}, {31'h0, AUX_SECONDARY_OK});
      end
      chk("enc_en", 32'h0, {31'h0, ENC_OUT_ENABLE});
      bus(1'b1, dss_pkg::OFS_AUXDIV, 32'h3);
      wait_cyc(80);
      chk("auxpos", 32'h1555, AUX_POSITION);
      dss_switch_model_i.set_fb(1'b0, 1'b0, 3'h3, 16'hf000);
      wait_cyc(3);
      dss_switch_model_i.set_fb(1'b0, 1'b0, 3'h3, 16'h1000);
      bus(1'b1, dss_pkg::OFS_AUXDIV, 32'h10);
      wait_cyc(80);
      chk("auxpos", 32'h1100, AUX_POSITION);
      rd("auxpos_reg", dss_pkg::OFS_AUXPOS, 32'h1100);
      rd("lines_reg", dss_pkg::OFS_LINES, 32'h1f4);
      rd("status", dss_pkg::OFS_STATUS, 32'h18);
      // Lane 1 only: the divider merges its upper byte, a one-byte register ignores it
      AVS_BYTEENABLE <= 4'h2;
      bus(1'b1, dss_pkg::OFS_AUXDIV, 32'h00001200);
      bus(1'b1, dss_pkg::OFS_OPSEL, 32'h2);
      AVS_BYTEENABLE <= 4'hf;
      rd("auxdiv", dss_pkg::OFS_AUXDIV, 32'h1210);
      rd("opsel", dss_pkg::OFS_OPSEL, 32'h0);
      stop_test();
   end
endmodule : tb_drive_setup_switch_decoder
`default_nettype wire
